// File: tb/ucr_usb_config_tb_top.sv
// Purpose: Self-checking bench for the USB configuration register block
// Assumes: APB answers with zero wait states; pstrb always selects all lanes
// Notes: Scenarios cover reset values, fields, unmapped access, stall, calibration, restore
module ucr_usb_config_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ucr_pkg::*;
	logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [UCR_AW-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic image_load = 0, usb_bus_reset = 0, lite_reset = 0, reset_protect = 0;
	logic sync_loss = 0, stall_clear = 0, bulk_out_stall, ss_link_up = 0, ss_cal_done = 0;
	logic ss_cal_run, core_dp_out = 1, core_dm_out = 0, core_drive = 1, core_dp_in, core_dm_in;
	logic usb2_pos_pad_in = 0, usb2_neg_pad_in = 1, usb2_pos_pad_out, usb2_neg_pad_out;
	logic usb2_pad_oe_n;
	ucr_image_t image_data = '0;
	ucr_phy_ctl_t phy_ctl;
	int mismatches = 0, num_checks = 0;
	ucr_usb_config ucr_usb_config_i (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .image_load, .image_data,
		.usb_bus_reset, .lite_reset, .reset_protect, .sync_loss, .stall_clear,
		.bulk_out_stall, .ss_link_up, .ss_cal_done, .ss_cal_run, .phy_ctl, .core_dp_out,
		.core_dm_out, .core_drive, .core_dp_in, .core_dm_in, .usb2_pos_pad_in,
		.usb2_neg_pad_in, .usb2_pos_pad_out, .usb2_neg_pad_out, .usb2_pad_oe_n);
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: bit %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [UCR_AW-1:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [31:0] exp);
		apb(1'b0, UCR_CFG_OFS, 32'h0);
		chk_word(rd, exp);
		chk_word({21'h0, phy_ctl}, {21'h0, exp[11:1]});
	endtask
	// Pulse select: 0 sync loss, 1 stall clear, 2 image load, 3 USB reset, 4 lite reset
	task automatic drive_pulse(input int sel, input logic v);
		case (sel)
			0: sync_loss <= v;
			1: stall_clear <= v;
			2: image_load <= v;
			3: usb_bus_reset <= v;
			default: lite_reset <= v;
		endcase
	endtask
	task automatic pulse(input int sel);
		@(posedge clk_sys);
		drive_pulse(sel, 1'b1);
		@(posedge clk_sys);
		drive_pulse(sel, 1'b0);
		#1;
	endtask
	task automatic t_pads(input logic sw);
		chk_bit(usb2_pos_pad_out, sw ? core_dm_out : core_dp_out);
		chk_bit(usb2_neg_pad_out, sw ? core_dp_out : core_dm_out);
		chk_bit(core_dp_in, sw ? usb2_neg_pad_in : usb2_pos_pad_in);
		chk_bit(core_dm_in, sw ? usb2_pos_pad_in : usb2_neg_pad_in);
		chk_bit(usb2_pad_oe_n, 1'b0);
	endtask
	task automatic t_fields();
		int v;
		apb(1'b1, UCR_CFG_OFS, 32'hffffcffe);
		rdchk(32'h00000ffe);
		for (v = 0; v < 4; v++) begin
			apb(1'b1, UCR_CFG_OFS, (v << 5) | (v << 3));
			rdchk((v << 5) | (v << 3));
		end
		apb(1'b1, 12'h004, 32'h00000ffe);
		chk_bit(err, 1'b1);
		apb(1'b0, 12'h004, 32'h0);
		chk_bit(err, 1'b1);
		chk_word(rd, 32'h0);
		chk_bit(pready, 1'b1);
		rdchk(32'h00000078);
	endtask
	task automatic t_stall();
		apb(1'b1, UCR_CFG_OFS, 32'h0);
		pulse(0);
		chk_bit(bulk_out_stall, 1'b1);
		pulse(1);
		chk_bit(bulk_out_stall, 1'b0);
		apb(1'b1, UCR_CFG_OFS, 32'h1);
		pulse(0);
		chk_bit(bulk_out_stall, 1'b0);
	endtask
	task automatic t_cal();
		int n;
		ss_link_up <= 1'b0;
		apb(1'b1, UCR_CFG_OFS, 32'h1000);
		rdchk(32'h1000);
		for (n = 0; n < 20 && ss_cal_run !== 1'b1; n++) @(posedge clk_sys);
		chk_bit(ss_cal_run, 1'b1);
		ss_cal_done <= 1'b1;
		for (n = 0; n < 10; n++) begin
			apb(1'b0, UCR_CFG_OFS, 32'h0);
			if (rd[12] === 1'b0) break;
		end
		chk_word(rd, 32'h0);
		ss_cal_done <= 1'b0;
		repeat (6) @(posedge clk_sys);
	endtask
	task automatic t_restore();
		image_data <= '{1'b1, 4'h3, 2'h2, 2'h1, 1'b0, 1'b1};
		pulse(2);
		rdchk(32'h000021ca);
		t_pads(1'b1);
		chk_bit(phy_ctl.ss_lane_loopback, 1'b0);
		apb(1'b1, UCR_CFG_OFS, 32'h00002800);
		pulse(3);
		rdchk(32'h000029ca);
		apb(1'b1, UCR_CFG_OFS, 32'h00002800);
		reset_protect <= 1'b1;
		pulse(4);
		rdchk(32'h00002800);
		reset_protect <= 1'b0;
		pulse(4);
		rdchk(32'h000029ca);
	endtask
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#(25 * 20000);
		mismatches++;
		test_done();
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		rdchk(32'h00000384);
		t_pads(1'b0);
		t_fields();
		t_stall();
		t_cal();
		t_restore();
		test_done();
	end
endmodule

// File: verilog/ucr_cal_ctrl.sv
// Purpose: Sequences one Super-Speed termination calibration per request
// Assumes: cal_done and link_up come from the PHY clock domain
// Notes: A request waits while the link is operational
module ucr_cal_ctrl (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic start,
	input wire logic link_up_async,
	input wire logic cal_done_async,
	output logic phy_cal_req,
	output logic finished
);
	import ucr_pkg::*;

	ucr_cal_state_t state_r, state_nxt;
	logic link_s1_r, link_s2_r, done_s1_r, done_s2_r;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			link_s1_r <= 1'b0;
			link_s2_r <= 1'b0;
			done_s1_r <= 1'b0;
			done_s2_r <= 1'b0;
		end else begin
			link_s1_r <= link_up_async;
			link_s2_r <= link_s1_r;
			done_s1_r <= cal_done_async;
			done_s2_r <= done_s1_r;
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			UCR_CAL_IDLE: if (start) state_nxt = UCR_CAL_WAIT_LINK;
			UCR_CAL_WAIT_LINK: if (!link_s2_r && !done_s2_r) state_nxt = UCR_CAL_RUN;
			UCR_CAL_RUN: if (done_s2_r) state_nxt = UCR_CAL_FINISH;
			UCR_CAL_FINISH: state_nxt = UCR_CAL_IDLE;
			default: state_nxt = UCR_CAL_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_r <= UCR_CAL_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign phy_cal_req = (state_r == UCR_CAL_RUN);
	assign finished = (state_r == UCR_CAL_FINISH);

endmodule

// File: verilog/ucr_pkg.sv
// Purpose: Shared constants and types for the USB configuration register block
// Assumes: APB with 32-bit data, one register word at byte offset 0
// Notes: Fallback values apply whenever no configuration image has been loaded
package ucr_pkg;

	localparam logic [11:0] UCR_CFG_OFS = 12'h000;
	localparam int UCR_AW = 12;

	// Field positions inside the configuration word
	localparam int UCR_PIN_SWAP_BIT = 13;
	localparam int UCR_CAL_REQ_BIT = 12;
	localparam int UCR_LOOPBACK_BIT = 11;
	localparam int UCR_BURST_LSB = 7;
	localparam int UCR_SQUELCH_LSB = 5;
	localparam int UCR_BOOST_LSB = 3;
	localparam int UCR_LINK_PM_BIT = 2;
	localparam int UCR_POWER_BIT = 1;
	localparam int UCR_NO_STALL_BIT = 0;
	localparam int UCR_USED_BITS = 14;

	// Fallback values when no image is present
	localparam logic [3:0] UCR_BURST_RST = 4'h7;
	localparam logic [1:0] UCR_SQUELCH_RST = 2'h0;
	localparam logic [1:0] UCR_BOOST_RST = 2'h0;
	localparam logic UCR_LINK_PM_RST = 1'b1;
	localparam logic UCR_POWER_RST = 1'b0;
	localparam logic UCR_PIN_SWAP_RST = 1'b0;
	localparam logic UCR_LOOPBACK_RST = 1'b0;
	localparam logic UCR_NO_STALL_RST = 1'b0;

	// Configuration image delivered by the loader
	typedef struct packed {
		logic eeprom_flag_pin_exchange;
		logic [3:0] burst;
		logic [1:0] eeprom_flag_squelch;
		logic [1:0] eeprom_flag_drive_boost;
		logic eeprom_flag_link_pm;
		logic eeprom_flag_power_source;
	} ucr_image_t;

	localparam ucr_image_t UCR_IMAGE_RST = '{UCR_PIN_SWAP_RST, UCR_BURST_RST,
		UCR_SQUELCH_RST, UCR_BOOST_RST, UCR_LINK_PM_RST, UCR_POWER_RST};

	// Static PHY and link settings driven from the register
	typedef struct packed {
		logic ss_lane_loopback;
		logic [3:0] max_burst;
		logic [1:0] squelch_level_adjust;
		logic [1:0] hs_drive_boost;
		logic link_pm_support;
		logic power_source_select;
	} ucr_phy_ctl_t;

	typedef enum {UCR_CAL_IDLE, UCR_CAL_WAIT_LINK, UCR_CAL_RUN, UCR_CAL_FINISH} ucr_cal_state_t;

endpackage

// File: verilog/ucr_usb_config.sv
// Purpose: USB configuration register with APB access and PHY/link controls
// Assumes: Loader, USB reset, lite reset and sync-loss pulses are on clk_sys
// Notes: Only offset 0 is mapped; other offsets answer with pslverr
module ucr_usb_config (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ucr_pkg::UCR_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic image_load,
	input wire ucr_pkg::ucr_image_t image_data,
	input wire logic usb_bus_reset,
	input wire logic lite_reset,
	input wire logic reset_protect,
	input wire logic sync_loss,
	input wire logic stall_clear,
	output logic bulk_out_stall,
	input wire logic ss_link_up,
	input wire logic ss_cal_done,
	output logic ss_cal_run,
	output ucr_pkg::ucr_phy_ctl_t phy_ctl,
	input wire logic core_dp_out,
	input wire logic core_dm_out,
	input wire logic core_drive,
	output logic core_dp_in,
	output logic core_dm_in,
	input wire logic usb2_pos_pad_in,
	input wire logic usb2_neg_pad_in,
	output logic usb2_pos_pad_out,
	output logic usb2_neg_pad_out,
	output logic usb2_pad_oe_n
);
	import ucr_pkg::*;

	logic pin_swap_r, cal_req_r, loopback_r, link_pm_r, power_r, no_stall_r;
	logic [3:0] burst_r;
	logic [1:0] squelch_r, boost_r;
	ucr_image_t image_r;
	logic stall_r;
	logic [31:0] rdata_r;
	logic err_r;

	// Address decode and bus phases
	wire logic hit = (paddr == UCR_CFG_OFS);
	wire logic setup_ph = psel && !penable;
	wire logic access_ph = psel && penable;
	wire logic wr_en = access_ph && pwrite && hit;
	wire logic lane0 = wr_en && pstrb[0];
	wire logic lane1 = wr_en && pstrb[1];
	wire logic restore = (usb_bus_reset || lite_reset) && !reset_protect;
	wire logic cal_start = lane1 && pwdata[UCR_CAL_REQ_BIT] && !cal_req_r;
	wire logic cal_finished;

	// Read view; reserved bits stay zero
	wire logic [31:0] cfg_view = {18'h0, pin_swap_r, cal_req_r, loopback_r, burst_r,
		squelch_r, boost_r, link_pm_r, power_r, no_stall_r};

	// APB answer: data captured in setup, zero wait states
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_r <= 32'h0;
			err_r <= 1'b0;
		end else if (setup_ph) begin
			rdata_r <= (hit && !pwrite) ? cfg_view : 32'h0;
			err_r <= !hit;
		end
	end

	assign prdata = rdata_r;
	assign pready = 1'b1;
	assign pslverr = access_ph && err_r;

	// Last loaded image, used for restore
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			image_r <= UCR_IMAGE_RST;
		end else if (image_load) begin
			image_r <= image_data;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pin_swap_r <= UCR_PIN_SWAP_RST;
		end else if (image_load) begin
			pin_swap_r <= image_data.eeprom_flag_pin_exchange;
		end
	end

	// loopback and sync-loss policy, plain write fields
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			loopback_r <= UCR_LOOPBACK_RST;
			no_stall_r <= UCR_NO_STALL_RST;
		end else begin
			if (lane1) loopback_r <= pwdata[UCR_LOOPBACK_BIT];
			if (lane0) no_stall_r <= pwdata[UCR_NO_STALL_BIT];
		end
	end

	// protected fields: image load, restore, then write
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			burst_r <= UCR_BURST_RST;
			squelch_r <= UCR_SQUELCH_RST;
			boost_r <= UCR_BOOST_RST;
			link_pm_r <= UCR_LINK_PM_RST;
			power_r <= UCR_POWER_RST;
		end else if (image_load) begin
			burst_r <= image_data.burst;
			squelch_r <= image_data.eeprom_flag_squelch;
			boost_r <= image_data.eeprom_flag_drive_boost;
			link_pm_r <= image_data.eeprom_flag_link_pm;
			power_r <= image_data.eeprom_flag_power_source;
		end else if (restore) begin
			burst_r <= image_r.burst;
			squelch_r <= image_r.eeprom_flag_squelch;
			boost_r <= image_r.eeprom_flag_drive_boost;
			link_pm_r <= image_r.eeprom_flag_link_pm;
			power_r <= image_r.eeprom_flag_power_source;
		end else begin
			if (lane0) squelch_r <= pwdata[UCR_SQUELCH_LSB +: 2];
			if (lane0) boost_r <= pwdata[UCR_BOOST_LSB +: 2];
			if (lane0) link_pm_r <= pwdata[UCR_LINK_PM_BIT];
			if (lane0) power_r <= pwdata[UCR_POWER_BIT];
			if (lane0 && lane1) burst_r <= pwdata[UCR_BURST_LSB +: 4];
			else if (lane0) burst_r <= {burst_r[3:1], pwdata[UCR_BURST_LSB]};
			else if (lane1) burst_r <= {pwdata[10:8], burst_r[0]};
		end
	end

	// calibration request, write of zero has no effect
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cal_req_r <= 1'b0;
		end else if (cal_start) begin
			cal_req_r <= 1'b1;
		end else if (cal_finished) begin
			cal_req_r <= 1'b0;
		end
	end

	// start deferred while the link reports operational
	ucr_cal_ctrl u_cal (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(cal_start),
		.link_up_async(ss_link_up),
		.cal_done_async(ss_cal_done),
		.phy_cal_req(ss_cal_run),
		.finished(cal_finished)
	);

	// sticky stall; a new loss beats a clear
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stall_r <= 1'b0;
		end else if (sync_loss && !no_stall_r) begin
			stall_r <= 1'b1;
		end else if (stall_clear) begin
			stall_r <= 1'b0;
		end
	end

	assign bulk_out_stall = stall_r;

	// static controls to PHY and link
	assign phy_ctl = '{loopback_r, burst_r, squelch_r, boost_r, link_pm_r, power_r};

	// USB 2.0 pad exchange; Super-Speed lanes have no mux
	assign usb2_pos_pad_out = pin_swap_r ? core_dm_out : core_dp_out;
	assign usb2_neg_pad_out = pin_swap_r ? core_dp_out : core_dm_out;
	assign usb2_pad_oe_n = !core_drive;
	assign core_dp_in = pin_swap_r ? usb2_neg_pad_in : usb2_pos_pad_in;
	assign core_dm_in = pin_swap_r ? usb2_pos_pad_in : usb2_neg_pad_in;

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	pad_swap_a: assert property (pin_swap_r |-> usb2_pos_pad_out == core_dm_out
		&& core_dm_in == usb2_pos_pad_in) else $error("pad exchange wrong");
	cal_start_a: assert property (cal_start |=> cal_req_r
		##[1:4] ss_cal_run || ss_link_up || ss_cal_done) else $error("calibration not started");
	cal_clear_a: assert property (cal_finished && !cal_start |=> !cal_req_r)
		else $error("request not cleared");
	loop_write_a: assert property (lane1 |=> phy_ctl.ss_lane_loopback == $past(pwdata[11]))
		else $error("loopback not written");
	burst_write_a: assert property (wr_en && pstrb[1:0] == 2'b11 && !image_load && !restore
		|=> phy_ctl.max_burst == $past(pwdata[10:7])) else $error("burst not written");
	image_load_a: assert property (image_load |=> burst_r == $past(image_data.burst)
		&& link_pm_r == $past(image_data.eeprom_flag_link_pm)) else $error("image not loaded");
	restore_img_a: assert property (restore && !image_load |=> squelch_r ==
		image_r.eeprom_flag_squelch && power_r == image_r.eeprom_flag_power_source)
		else $error("restore failed");
	protect_hold_a: assert property ((usb_bus_reset || lite_reset) && reset_protect
		&& !wr_en && !image_load |=> $stable(boost_r) && $stable(burst_r))
		else $error("protected field changed");
	stall_set_a: assert property (sync_loss && !no_stall_r |=> bulk_out_stall)
		else $error("stall missing");
	no_stall_a: assert property (!bulk_out_stall && no_stall_r && !sync_loss |=> !bulk_out_stall)
		else $error("stall raised");
	rsvd_zero_a: assert property (setup_ph && hit && !pwrite |=> prdata[31:14] == 18'h0)
		else $error("reserved bits set");

endmodule
